// [core/hcd_pkg.sv]
`default_nettype none
package hcd_pkg;
   // clock rate
   localparam int CLK_HZ          = 100_000_000;
   localparam int CLK_MHZ         = 100;
   localparam int CLK_PERIOD_NS   = 10;

   // start-up latencies, typical, in microseconds
   localparam int START_GO_US     = 700;
   localparam int START_EN_US     = 1500;
   localparam int START_GO_CYC    = START_GO_US * CLK_MHZ;
   localparam int START_EN_CYC    = START_EN_US * CLK_MHZ;
   localparam int START_CNT_W     = 18;

   // output carrier, hertz
   localparam int PWM_MIN_HZ      = 19_500;
   localparam int PWM_TYP_HZ      = 20_500;
   localparam int PWM_MAX_HZ      = 21_500;
   localparam int CARRIER_CYC     = CLK_HZ / PWM_TYP_HZ;
   localparam int CARRIER_W       = 13;

   // resonant actuator band, hertz
   localparam int LRA_MIN_HZ      = 125;
   localparam int LRA_OL_HZ       = 200;
   localparam int RES_TIMEOUT_CYC = CLK_HZ / (2 * LRA_MIN_HZ);
   localparam int LRA_OL_HALF_CYC = CLK_HZ / (2 * LRA_OL_HZ);
   localparam int HALF_W          = 20;
   localparam int PERIOD_W        = HALF_W + 1;

   // drive levels
   localparam int LEVEL_W         = 8;
   localparam logic [LEVEL_W-1:0] LEVEL_FULL  = 8'hFF;
   localparam logic [LEVEL_W-1:0] BRAKE_FLOOR = 8'h08;

   // actuator type select encoding
   localparam logic ACT_ROTATING  = 1'b0;
   localparam logic ACT_RESONANT  = 1'b1;

   // input mode encoding
   localparam logic MODE_INTERNAL = 1'b0;
   localparam logic MODE_PWM_ANA  = 1'b1;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_WAIT  = 2'b01,
      ST_DRIVE = 2'b10,
      ST_BRAKE = 2'b11
   } hcd_state_t;
endpackage
`default_nettype wire

// [core/hcd_pwm_carrier.sv]
`default_nettype none
module hcd_pwm_carrier
   import hcd_pkg::*;
#(
   parameter int CARRIER = CARRIER_CYC
) (
   // clock and reset
   input  wire logic                clock,
   input  wire logic                rstn,
   // duty request
   input  wire logic [LEVEL_W-1:0]  duty,
   // carrier outputs
   output logic                     pwm_on,
   output logic [CARRIER_W-1:0]     carrier_cnt
);
   logic [CARRIER_W-1:0]            cnt_ff;
   logic [LEVEL_W+CARRIER_W-1:0]    prod;
   logic [CARRIER_W-1:0]            thresh;

   // free-running carrier counter
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt_ff <= '0;
      end else if (cnt_ff == CARRIER_W'(CARRIER - 1)) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   // duty scaled onto one carrier period, full level is always on
   always_comb begin
      prod   = duty * (LEVEL_W+CARRIER_W)'(CARRIER);
      thresh = prod[LEVEL_W+CARRIER_W-1:LEVEL_W];
      pwm_on = (duty == LEVEL_FULL) || (cnt_ff < thresh);
   end

   assign carrier_cnt = cnt_ff;

   carrier_range_a: assert property (@(posedge clock) disable iff (!rstn)
      (cnt_ff == CARRIER_W'(CARRIER - 1)) |=> (cnt_ff == '0) ##1 (cnt_ff == CARRIER_W'(1)))
      else $error("carrier counter did not wrap at its period");
endmodule // hcd_pwm_carrier
`default_nettype wire

// [core/hcd_res_tracker.sv]
`default_nettype none
module hcd_res_tracker
   import hcd_pkg::*;
#(
   parameter int TIMEOUT = RES_TIMEOUT_CYC
) (
   // clock and reset
   input  wire logic                clock,
   input  wire logic                rstn,
   // control and feedback
   input  wire logic                run,
   input  wire logic                bemf_cross,
   // tracking results
   output logic                     locked,
   output logic                     phase,
   output logic [PERIOD_W-1:0]      period
);
   logic [HALF_W-1:0]               half_cnt_ff;
   logic                            locked_ff;
   logic                            phase_ff;
   logic [PERIOD_W-1:0]             period_ff;
   logic                            timeout;

   assign timeout = (half_cnt_ff == HALF_W'(TIMEOUT));

   // half-cycle timer, restarted by every back-emf crossing; the crossing cycle counts as the first
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         half_cnt_ff <= '0;
      end else if (!run || bemf_cross) begin
         half_cnt_ff <= HALF_W'(1);
      end else if (!timeout) begin
         half_cnt_ff <= half_cnt_ff + 1'b1;
      end
   end

   // lock after the first half cycle, lost when crossings stop
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         locked_ff <= 1'b0;
      end else if (!run || timeout) begin
         locked_ff <= 1'b0;
      end else if (bemf_cross) begin
         locked_ff <= 1'b1;
      end
   end

   // drive phase follows the actuator's own crossings
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         phase_ff <= 1'b1;
      end else if (!run) begin
         phase_ff <= 1'b1;
      end else if (bemf_cross) begin
         phase_ff <= ~phase_ff;
      end
   end

   // period measured on every crossing while run is high, held otherwise
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         period_ff <= '0;
      end else if (run && bemf_cross) begin
         period_ff <= {half_cnt_ff, 1'b0};
      end
   end

   assign locked = locked_ff;
   assign phase  = phase_ff;
   assign period = period_ff;

   lock_half_a: assert property (@(posedge clock) disable iff (!rstn)
      (run && bemf_cross && !timeout) |=> locked_ff)
      else $error("no lock after first half cycle");
   period_update_a: assert property (@(posedge clock) disable iff (!rstn)
      (run && bemf_cross) |=> (period_ff == {$past(half_cnt_ff), 1'b0}))
      else $error("period not updated from measured half cycle");
   phase_follow_a: assert property (@(posedge clock) disable iff (!rstn)
      (run && bemf_cross) ##1 run |-> (phase_ff != $past(phase_ff)))
      else $error("drive phase did not follow crossing");
   bemf_loss_a: assert property (@(posedge clock) disable iff (!rstn)
      (run && timeout && !bemf_cross) |=> !locked_ff)
      else $error("lock held without back-emf crossings");
endmodule // hcd_res_tracker
`default_nettype wire

// [core/hcd_top.sv]
// Contract
// - host sets actuator type first; drive and feedback follow that selection.
// - resonance lock is reached half a resonance cycle after drive starts.
// - drive frequency follows resonance drift on every cycle.
// - tracking comes from live back-emf crossings, never a stored frequency.
// - resonance engine needs no calibration; level calibration leaves it alone.
// - measured resonance period is readable and updated live while tracking.
// - drive starts about 0.7 ms after launch bit or external cue.
// - in pwm or analog mode drive starts about 1.5 ms after enable.
// - open-loop drive uses an internal carrier between 19.5 and 21.5 kHz.
// - closed loop adds overdrive and braking automatically from feedback.
`default_nettype none
module hcd_top
   import hcd_pkg::*;
#(
   parameter int GO_LATENCY  = START_GO_CYC,
   parameter int EN_LATENCY  = START_EN_CYC,
   parameter int CARRIER     = CARRIER_CYC,
   parameter int RES_TIMEOUT = RES_TIMEOUT_CYC,
   parameter int OL_HALF     = LRA_OL_HALF_CYC
) (
   // clock and reset
   input  wire logic                clock,
   input  wire logic                rstn,
   // host configuration levels
   input  wire logic                actuator_type_select,
   input  wire logic                input_mode,
   input  wire logic                closed_loop_en,
   input  wire logic                level_cal_active,
   // launch controls
   input  wire logic                launch_go,
   input  wire logic                external_cue_pin,
   input  wire logic                chip_enable,
   // drive level and actuator feedback
   input  wire logic [LEVEL_W-1:0]  drive_level,
   input  wire logic [LEVEL_W-1:0]  bemf_level,
   input  wire logic                bemf_cross,
   // bridge outputs
   output logic                     out_pos_ff,
   output logic                     out_neg_ff,
   // status
   output logic                     drive_active_ff,
   output logic                     braking_ff,
   output logic                     res_locked_ff,
   output logic [PERIOD_W-1:0]      res_period_ff
);
   hcd_state_t                      state_ff;
   hcd_state_t                      nxt_state;
   logic [START_CNT_W-1:0]          wait_cnt_ff;
   logic [START_CNT_W-1:0]          wait_target_ff;
   logic                            cue_prev_ff;
   logic                            en_prev_ff;
   logic [HALF_W-1:0]               ol_cnt_ff;
   logic                            ol_phase_ff;
   logic                            lra_sel;
   logic                            start_go;
   logic                            start_en;
   logic                            stop_req;
   logic                            fb_high;
   logic                            trk_run;
   logic                            trk_locked;
   logic                            trk_phase;
   logic [PERIOD_W-1:0]             trk_period;
   logic [LEVEL_W+1:0]              cl_sum;
   logic [LEVEL_W-1:0]              duty;
   logic                            pwm_on;
   logic                            polarity;
   logic                            bridge_on;

   assign lra_sel = (actuator_type_select == ACT_RESONANT);

   // launch sources; level calibration is not an input to tracking
   assign start_go = (input_mode == MODE_INTERNAL)
                     && (launch_go || (external_cue_pin && !cue_prev_ff));
   assign start_en = (input_mode == MODE_PWM_ANA) && chip_enable && !en_prev_ff;
   assign stop_req = (input_mode == MODE_INTERNAL) ? (drive_level == '0) : !chip_enable;
   assign fb_high  = closed_loop_en && (bemf_level > BRAKE_FLOOR);
   assign trk_run  = (state_ff == ST_DRIVE) && lra_sel && closed_loop_en;

   // edge memory for cue pin and enable
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cue_prev_ff <= 1'b0;
         en_prev_ff  <= 1'b0;
      end else begin
         cue_prev_ff <= external_cue_pin;
         en_prev_ff  <= chip_enable;
      end
   end

   // drive sequencing
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (start_go || start_en) begin
               nxt_state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if ((input_mode == MODE_PWM_ANA) && !chip_enable) begin
               nxt_state = ST_IDLE;
            end else if (wait_cnt_ff == wait_target_ff) begin
               nxt_state = ST_DRIVE;
            end
         end
         ST_DRIVE: begin
            if (stop_req) begin
               nxt_state = fb_high ? ST_BRAKE : ST_IDLE;
            end
         end
         ST_BRAKE: begin
            if (!fb_high) begin
               nxt_state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // sequencing checks
   brake_release_a: assert property (@(posedge clock) disable iff (!rstn)
      (state_ff == ST_BRAKE && !fb_high) |=> (state_ff == ST_IDLE))
      else $error("brake held after feedback settled");
   enable_abort_a: assert property (@(posedge clock) disable iff (!rstn)
      (state_ff == ST_WAIT && input_mode == MODE_PWM_ANA && !chip_enable) |=> (state_ff == ST_IDLE))
      else $error("start not aborted when enable dropped");
   drive_hold_a: assert property (@(posedge clock) disable iff (!rstn)
      (state_ff == ST_DRIVE && !stop_req) |=> (state_ff == ST_DRIVE))
      else $error("drive left without a stop request");

   // start-up latency counter, target picked by launch source
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wait_cnt_ff    <= '0;
         wait_target_ff <= '0;
      end else if (state_ff == ST_IDLE) begin
         wait_cnt_ff    <= '0;
         wait_target_ff <= start_en ? START_CNT_W'(EN_LATENCY - 1)
                                    : START_CNT_W'(GO_LATENCY - 1);
      end else if (state_ff == ST_WAIT) begin
         wait_cnt_ff <= wait_cnt_ff + 1'b1;
      end
   end

   // fixed commutation for resonant actuator without feedback
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ol_cnt_ff   <= '0;
         ol_phase_ff <= 1'b1;
      end else if (state_ff != ST_DRIVE) begin
         ol_cnt_ff   <= '0;
         ol_phase_ff <= 1'b1;
      end else if (ol_cnt_ff == HALF_W'(OL_HALF - 1)) begin
         ol_cnt_ff   <= '0;
         ol_phase_ff <= ~ol_phase_ff;
      end else begin
         ol_cnt_ff <= ol_cnt_ff + 1'b1;
      end
   end

   // open-loop commutation check
   open_commute_a: assert property (@(posedge clock) disable iff (!rstn)
      (state_ff == ST_DRIVE && ol_cnt_ff == HALF_W'(OL_HALF - 1)) |=> (ol_phase_ff != $past(ol_phase_ff)))
      else $error("open-loop drive did not commutate");

   // closed loop: twice the request minus feedback, clamped (overdrive)
   always_comb begin
      cl_sum = {2'b00, drive_level} + {2'b00, drive_level} - {2'b00, bemf_level};
      if (state_ff == ST_BRAKE) begin
         duty = LEVEL_FULL;
      end else if (!closed_loop_en) begin
         duty = drive_level;
      end else if (cl_sum[LEVEL_W+1]) begin
         duty = '0;
      end else if (cl_sum[LEVEL_W]) begin
         duty = LEVEL_FULL;
      end else begin
         duty = cl_sum[LEVEL_W-1:0];
      end
   end

   // duty checks
   open_duty_a: assert property (@(posedge clock) disable iff (!rstn)
      (state_ff == ST_DRIVE && !closed_loop_en) |-> (duty == drive_level))
      else $error("open-loop duty differs from request");
   brake_duty_a: assert property (@(posedge clock) disable iff (!rstn)
      (state_ff == ST_BRAKE) |-> (duty == LEVEL_FULL))
      else $error("brake not applied at full level");

   // bridge polarity per actuator type, reversed while braking
   always_comb begin
      if (!lra_sel) begin
         polarity = 1'b1;
      end else if (closed_loop_en) begin
         polarity = trk_phase;
      end else begin
         polarity = ol_phase_ff;
      end
      if (state_ff == ST_BRAKE) begin
         polarity = ~polarity;
      end
   end

   // polarity check
   brake_reverse_a: assert property (@(posedge clock) disable iff (!rstn)
      (state_ff == ST_BRAKE && !lra_sel) |-> !polarity)
      else $error("rotating motor not reversed for brake");

   hcd_pwm_carrier #(
      .CARRIER     (CARRIER)
   ) u_carrier (
      .clock       (clock),
      .rstn        (rstn),
      .duty        (duty),
      .pwm_on      (pwm_on),
      .carrier_cnt ()
   );

   hcd_res_tracker #(
      .TIMEOUT     (RES_TIMEOUT)
   ) u_tracker (
      .clock       (clock),
      .rstn        (rstn),
      .run         (trk_run),
      .bemf_cross  (bemf_cross),
      .locked      (trk_locked),
      .phase       (trk_phase),
      .period      (trk_period)
   );

   // bridge may only switch while driving or braking
   assign bridge_on = (state_ff == ST_DRIVE) || (state_ff == ST_BRAKE);

   // registered bridge outputs
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         out_pos_ff <= 1'b0;
         out_neg_ff <= 1'b0;
      end else begin
         out_pos_ff <= bridge_on && pwm_on && polarity;
         out_neg_ff <= bridge_on && pwm_on && !polarity;
      end
   end

   // bridge checks
   bridge_exclusive_a: assert property (@(posedge clock) disable iff (!rstn)
      !(out_pos_ff && out_neg_ff))
      else $error("both bridge sides driven");
   idle_quiet_a: assert property (@(posedge clock) disable iff (!rstn)
      (state_ff == ST_IDLE || state_ff == ST_WAIT) |=> (!out_pos_ff && !out_neg_ff))
      else $error("bridge driven before drive state");

   // registered status; the period has no write path at all
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         drive_active_ff <= 1'b0;
         braking_ff      <= 1'b0;
         res_locked_ff   <= 1'b0;
         res_period_ff   <= '0;
      end else begin
         drive_active_ff <= (state_ff == ST_DRIVE);
         braking_ff      <= (state_ff == ST_BRAKE);
         res_locked_ff   <= trk_locked;
         res_period_ff   <= trk_period;
      end
   end

   rotating_polarity_a: assert property (@(posedge clock) disable iff (!rstn)
      (state_ff == ST_DRIVE && !lra_sel) |=> !out_neg_ff)
      else $error("rotating motor driven in reverse");
   go_latency_a: assert property (@(posedge clock) disable iff (!rstn)
      (state_ff == ST_IDLE && start_go && !start_en) |=>
         (wait_target_ff == START_CNT_W'(GO_LATENCY - 1)) && (state_ff == ST_WAIT))
      else $error("launch latency target wrong");
   en_latency_a: assert property (@(posedge clock) disable iff (!rstn)
      (state_ff == ST_IDLE && start_en) |=>
         (wait_target_ff == START_CNT_W'(EN_LATENCY - 1)) && (state_ff == ST_WAIT))
      else $error("enable latency target wrong");
   wait_done_a: assert property (@(posedge clock) disable iff (!rstn)
      (state_ff == ST_WAIT && wait_cnt_ff != wait_target_ff) |=> (state_ff != ST_DRIVE))
      else $error("drive began before latency elapsed");
   auto_brake_a: assert property (@(posedge clock) disable iff (!rstn)
      (state_ff == ST_DRIVE && stop_req && fb_high) |=> (state_ff == ST_BRAKE) ##1 braking_ff)
      else $error("no automatic brake at end of effect");
   overdrive_a: assert property (@(posedge clock) disable iff (!rstn)
      (state_ff == ST_DRIVE && closed_loop_en && bemf_level == '0 && drive_level[LEVEL_W-1])
         |-> (duty == LEVEL_FULL))
      else $error("no overdrive at start-up");
   period_hold_a: assert property (@(posedge clock) disable iff (!rstn)
      $stable(trk_period) |=> (res_period_ff == $past(trk_period)))
      else $error("reported period differs from tracker");
endmodule // hcd_top
`default_nettype wire

// [test/hcd_actuator_model.sv]
`default_nettype none
module hcd_actuator_model
   import hcd_pkg::*;
(
   // clock and reset
   input  wire logic                clock,
   input  wire logic                rstn,
   // drive state seen at the bridge
   input  wire logic                drive_active_ff,
   input  wire logic                braking_ff,
   // behaviour set by the bench
   input  wire logic                cross_en,
   input  wire logic [15:0]         half_cyc,
   // feedback to the device
   output logic [LEVEL_W-1:0]       bemf_level,
   output logic                     bemf_cross
);
   logic        tick_ff;
   logic [15:0] cnt_ff;

   // speed builds slowly while driven, falls fast under brake, slowly coasting
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         bemf_level <= 8'h00;
         tick_ff    <= 1'b0;
      end else begin
         tick_ff <= ~tick_ff;
         if (drive_active_ff) begin
            if (tick_ff && bemf_level < 8'h40) begin
               bemf_level <= bemf_level + 8'h01;
            end
         end else if (braking_ff) begin
            bemf_level <= (bemf_level < 8'h02) ? 8'h00 : bemf_level - 8'h02;
         end else if (bemf_level != 8'h00) begin
            bemf_level <= bemf_level - 8'h01;
         end
      end
   end

   // zero crossings every half_cyc cycles, only while the mass is driven
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt_ff     <= 16'h0001;
         bemf_cross <= 1'b0;
      end else if (!(cross_en && drive_active_ff)) begin
         cnt_ff     <= 16'h0001;
         bemf_cross <= 1'b0;
      end else if (cnt_ff >= half_cyc) begin
         cnt_ff     <= 16'h0001;
         bemf_cross <= 1'b1;
      end else begin
         cnt_ff     <= cnt_ff + 16'h0001;
         bemf_cross <= 1'b0;
      end
   end
endmodule // hcd_actuator_model
`default_nettype wire

// [test/test_haptic_closed_loop_drive_control.sv]
`default_nettype none
module test_haptic_closed_loop_drive_control
   import hcd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int GO  = 20;
   localparam int EN  = 30;
   localparam int CAR = 16;
   localparam int RTO = 200;
   localparam int OLH = 50;

   // stimulus
   logic                clock                = 1'b0;
   logic                rstn                 = 1'b0;
   logic                actuator_type_select = ACT_ROTATING;
   logic                input_mode           = MODE_INTERNAL;
   logic                closed_loop_en       = 1'b0;
   logic                level_cal_active     = 1'b0;
   logic                launch_go            = 1'b0;
   logic                external_cue_pin     = 1'b0;
   logic                chip_enable          = 1'b0;
   logic [LEVEL_W-1:0]  drive_level          = 8'h00;
   logic                cross_en             = 1'b0;
   logic [15:0]         half_cyc             = 16'h001E;
   // observed
   logic [LEVEL_W-1:0]  bemf_level;
   logic                bemf_cross;
   logic                out_pos_ff;
   logic                out_neg_ff;
   logic                drive_active_ff;
   logic                braking_ff;
   logic                res_locked_ff;
   logic [PERIOD_W-1:0] res_period_ff;
   int                  num_errors = 0;
   int                  checked    = 0;

   // 100 MHz clock
   always #5 clock = ~clock;

   hcd_top #(.GO_LATENCY(GO), .EN_LATENCY(EN), .CARRIER(CAR), .RES_TIMEOUT(RTO), .OL_HALF(OLH)) hcd_top_inst (
      .clock(clock), .rstn(rstn), .actuator_type_select(actuator_type_select), .input_mode(input_mode),
      .closed_loop_en(closed_loop_en), .level_cal_active(level_cal_active), .launch_go(launch_go),
      .external_cue_pin(external_cue_pin), .chip_enable(chip_enable), .drive_level(drive_level),
      .bemf_level(bemf_level), .bemf_cross(bemf_cross), .out_pos_ff(out_pos_ff), .out_neg_ff(out_neg_ff),
      .drive_active_ff(drive_active_ff), .braking_ff(braking_ff), .res_locked_ff(res_locked_ff),
      .res_period_ff(res_period_ff));

   hcd_actuator_model hcd_actuator_model_inst (
      .clock(clock), .rstn(rstn), .drive_active_ff(drive_active_ff), .braking_ff(braking_ff),
      .cross_en(cross_en), .half_cyc(half_cyc), .bemf_level(bemf_level), .bemf_cross(bemf_cross));

   task automatic finish_test();
      $display("checked=%0d num_errors=%0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   function automatic logic pick(input int k);
      case (k)
         0: return drive_active_ff;
         1: return braking_ff;
         2: return res_locked_ff;
         3: return out_neg_ff;
         default: return out_pos_ff;
      endcase
   endfunction

   // bounded wait for an output to reach a level, counting clock edges
   task automatic wait_for(input int k, input logic v, input int bound, output int n);
      n = 0;
      #1;
      while (pick(k) !== v && n < bound) begin
         @(posedge clock);
         #1;
         n++;
      end
      if (pick(k) !== v) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, pick(k), v);
         finish_test();
      end
   endtask

   task automatic cfg(input logic typ, input logic md, input logic cl, input logic [LEVEL_W-1:0] lvl);
      @(posedge clock);
      actuator_type_select <= typ;
      input_mode           <= md;
      closed_loop_en       <= cl;
      drive_level          <= lvl;
   endtask

   // launch by go pulse, cue edge or enable; n counts edges until drive shows
   task automatic start(input int how, output int n);
      @(posedge clock);
      case (how)
         0: launch_go <= 1'b1;
         1: external_cue_pin <= 1'b1;
         default: chip_enable <= 1'b1;
      endcase
      @(posedge clock);
      launch_go        <= 1'b0;
      external_cue_pin <= 1'b0;
      wait_for(0, 1'b1, EN + 10, n);
   endtask

   task automatic stop();
      int n;
      @(posedge clock);
      drive_level <= 8'h00;
      chip_enable <= 1'b0;
      wait_for(0, 1'b0, 10, n);
      wait_for(1, 1'b0, 200, n);
   endtask

   // one full carrier period: high and low cycle counts
   task automatic pulse(output int hi, output int lo);
      int n;
      wait_for(4, 1'b0, CAR, n);
      wait_for(4, 1'b1, CAR, n);
      wait_for(4, 1'b0, CAR, hi);
      wait_for(4, 1'b1, CAR, lo);
   endtask

   task automatic t_latency();
      int n;
      int lat;
      for (int h = 0; h < 3; h++) begin
         lat = (h == 2) ? EN : GO;
         cfg(ACT_ROTATING, logic'(h == 2), 1'b0, 8'h80);
         start(h, n);
         check(32'(n >= lat && n <= lat + 3), 32'h1);
         stop();
      end
   endtask

   task automatic t_carrier();
      int   n;
      int   hi;
      int   lo;
      logic neg;
      cfg(ACT_ROTATING, MODE_INTERNAL, 1'b0, 8'h80);
      start(0, n);
      pulse(hi, lo);
      check(32'(hi + lo), 32'(CAR));
      check(32'(hi), 32'(CAR / 2));
      neg = 1'b0;
      repeat (2 * CAR) begin
         @(posedge clock);
         #1;
         neg = neg | out_neg_ff;
      end
      check(32'(neg), 32'h0);
      stop();
   endtask

   task automatic t_brake();
      int n;
      int hi1;
      int hi2;
      int lo;
      cfg(ACT_ROTATING, MODE_INTERNAL, 1'b1, 8'h60);
      start(0, n);
      pulse(hi1, lo);
      repeat (160) @(posedge clock);
      pulse(hi2, lo);
      check(32'(hi1 > hi2), 32'h1);
      @(posedge clock);
      drive_level <= 8'h00;
      wait_for(1, 1'b1, 5, n);
      check(32'(out_neg_ff), 32'h1);
      wait_for(1, 1'b0, 100, n);
      check(32'(bemf_level <= BRAKE_FLOOR), 32'h1);
      check(32'(drive_active_ff), 32'h0);
      cfg(ACT_ROTATING, MODE_INTERNAL, 1'b0, 8'h60);
      start(0, n);
      repeat (160) @(posedge clock);
      drive_level <= 8'h00;
      wait_for(0, 1'b0, 5, n);
      check(32'(braking_ff), 32'h0);
      stop();
   endtask

   task automatic t_track();
      int n;
      cfg(ACT_RESONANT, MODE_INTERNAL, 1'b1, 8'h80);
      half_cyc <= 16'h001E;
      cross_en <= 1'b1;
      start(0, n);
      wait_for(2, 1'b1, 40, n);
      check(32'(n <= 33), 32'h1);
      repeat (70) @(posedge clock);
      #1;
      check(32'(res_period_ff), 32'h3C);
      @(posedge clock);
      level_cal_active <= 1'b1;
      half_cyc         <= 16'h0028;
      repeat (100) @(posedge clock);
      #1;
      check(32'(res_period_ff), 32'h50);
      check(32'(res_locked_ff), 32'h1);
      @(posedge clock);
      level_cal_active <= 1'b0;
      cross_en         <= 1'b0;
      wait_for(2, 1'b0, RTO + 10, n);
      check(32'(n >= RTO - 40), 32'h1);
      stop();
   endtask

   task automatic t_open_lra();
      int n;
      cfg(ACT_RESONANT, MODE_INTERNAL, 1'b0, 8'hFF);
      start(0, n);
      wait_for(3, 1'b1, OLH + 10, n);
      check(32'(out_pos_ff), 32'h0);
      stop();
   endtask

   // reset, then every scenario in turn
   initial begin
      repeat (16) @(posedge clock);
      rstn <= 1'b1;
      #1;
      check(32'({drive_active_ff, braking_ff, res_locked_ff, out_pos_ff, out_neg_ff}), 32'h0);
      check(32'(res_period_ff), 32'h0);
      t_latency();
      t_carrier();
      t_brake();
      t_track();
      t_open_lra();
      finish_test();
   end
endmodule // test_haptic_closed_loop_drive_control
`default_nettype wire
